// File: rtl/cmpev_pkg.sv
// Purpose: shared constants and types for the comparator event control
// Assumes: 8-bit register port, cpu clock
// Notes: register offsets are byte addresses on the plain port
package cmpev_pkg;
   localparam logic [7:0] CMPEV_ADDR_CONTROL = 8'h9C;
   localparam logic [7:0] CMPEV_ADDR_CONFIG = 8'h9D;
   localparam logic [7:0] CMPEV_ADDR_IRQ = 8'hA0;
   localparam logic [7:0] CMPEV_ADDR_MASK = 8'hA1;
   localparam logic [7:0] CMPEV_ADDR_WAKE = 8'hA2;
   localparam int CMPEV_BIT_EN = 7;
   localparam int CMPEV_BIT_RESULT = 6;
   localparam int CMPEV_BIT_DIR = 0;
   localparam int CMPEV_BIT_PINEN = 1;
   localparam logic [3:0] CMPEV_CHAN_LAST = 4'hB;
   localparam int CMPEV_NCHAN = 12;
   localparam logic [1:0] CMPEV_DB_NONE = 2'h3;
   localparam logic [1:0] CMPEV_RST_REF = 2'h0;
   localparam logic [3:0] CMPEV_RST_CHAN = 4'h0;
   localparam logic [1:0] CMPEV_RST_DB = 2'h0;
   localparam logic [1:0] CMPEV_RST_IRQ = 2'h0;
   localparam logic [1:0] CMPEV_IRQ_EVENT = 2'h1;
   localparam logic [1:0] CMPEV_IRQ_WAKE = 2'h2;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } cmpev_bus_t;

   typedef struct packed {
      logic [CMPEV_NCHAN-1:0] take;
      logic [CMPEV_NCHAN-1:0] neg_sel;
   } cmpev_pins_t;
endpackage

// File: rtl/cmpev_top.sv
// Purpose: enable, channel, filter, edge and event logic of the comparator
// Assumes: analog comparator output arrives asynchronously on a pin
// Notes: channel index 0..7 port-1 pins 0..7, 8..11 port-5 pins 4..7
`timescale 1ns/1ps
// Operation
// - The result flag reads 1 while disabled, otherwise the comparator output.
// - The event flag sets on a filtered rise when direction is 0, fall when 1.
// - The event flag stays set until software clears it.
// - An interrupt is requested while the event flag and its enable are set.
// - In green mode any filtered change of the result wakes the device.
// - No wake from power-down mode is given by the comparator.
// - A wake edge matching the direction also sets the event flag.
// - The filter needs 1, 2 or 3 stable clocks for codes 0..2; code 3 passes.
// - Edges come from the filtered output only.
// - The result flag shows the unfiltered state; the event flag only edges.
// - Reference code 0,1,2/3 picks quarter, half, three quarters; the enable bit turns it on.
// - Channel codes 0..7 pick port-1 pins 0..7, codes 8..11 port-5 pins 4..7.
// - Only when enabled is the chosen pin forced to input and connected.
// - Deselected or disabled pins return to their own GPIO setting at once.
// - With enable at 0 all twelve pins stay general purpose.
// - The output pin enable drives the result on port-0 pin 0 instead of GPIO.
module cmpev_top (
   // clock and reset
   input wire logic i_clock,
   input wire logic i_rstn,
   // register port
   input wire cmpev_pkg::cmpev_bus_t i_bus,
   output logic [7:0] o_rdata,
   // comparator
   input wire logic i_cmp_raw,
   output logic o_ref_enable,
   output logic [1:0] o_ref_level_select,
   // pins
   output cmpev_pkg::cmpev_pins_t o_pins,
   input wire logic i_gpio_p00_out,
   input wire logic i_gpio_p00_oe,
   output logic o_result_out_pin,
   output logic o_result_out_pin_oe,
   // power and interrupt
   input wire logic i_green_mode,
   input wire logic i_powerdown_mode,
   output logic o_wakeup,
   output logic o_irq
);
   import cmpev_pkg::*;

   logic [1:0] rst_sync_q;
   logic rstn;
   logic [2:0] cmp_sync_q;
   logic cmp_stable;
   logic en_q;
   logic [1:0] ref_q;
   logic [3:0] chan_q;
   logic [1:0] db_q;
   logic pinen_q;
   logic dir_q;
   logic [1:0] irq_q;
   logic [1:0] mask_q;
   logic result;
   logic filt_q;
   logic [1:0] cnt_q;
   logic [1:0] need;
   logic filt_prev_q;
   logic rise;
   logic fall;
   logic event_hit;
   logic wake_hit;
   logic wr_irq;
   logic [7:0] rdata_d;
   logic [7:0] rdata_q;

   always_ff @(posedge i_clock or negedge i_rstn) begin
      if (!i_rstn) begin
         rst_sync_q <= 2'h0;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end
   assign rstn = rst_sync_q[1];

   // comparator output synchroniser; change counts when stages 2 and 3 agree
   always_ff @(posedge i_clock or negedge rstn) begin
      if (!rstn) begin
         cmp_sync_q <= 3'h7;
      end else begin
         cmp_sync_q <= {cmp_sync_q[1:0], i_cmp_raw};
      end
   end
   assign cmp_stable = (cmp_sync_q[2] == cmp_sync_q[1]);

   // control registers
   always_ff @(posedge i_clock or negedge rstn) begin
      if (!rstn) begin
         en_q <= 1'b0;
         ref_q <= CMPEV_RST_REF;
         chan_q <= CMPEV_RST_CHAN;
      end else if (i_bus.wr && i_bus.addr == CMPEV_ADDR_CONTROL) begin
         en_q <= i_bus.wdata[CMPEV_BIT_EN];
         ref_q <= i_bus.wdata[5:4];
         chan_q <= i_bus.wdata[3:0];
      end
   end

   always_ff @(posedge i_clock or negedge rstn) begin
      if (!rstn) begin
         db_q <= CMPEV_RST_DB;
         pinen_q <= 1'b0;
         dir_q <= 1'b0;
      end else if (i_bus.wr && i_bus.addr == CMPEV_ADDR_CONFIG) begin
         db_q <= i_bus.wdata[3:2];
         pinen_q <= i_bus.wdata[CMPEV_BIT_PINEN];
         dir_q <= i_bus.wdata[CMPEV_BIT_DIR];
      end
   end

   always_ff @(posedge i_clock or negedge rstn) begin
      if (!rstn) begin
         mask_q <= CMPEV_RST_IRQ;
      end else if (i_bus.wr && i_bus.addr == CMPEV_ADDR_MASK) begin
         mask_q <= i_bus.wdata[1:0];
      end
   end

   // result flag: forced high while disabled, unfiltered otherwise
   assign result = en_q ? cmp_sync_q[2] : 1'b1;

   // de-bounce: new level must hold for need+1 clocks
   assign need = db_q;
   always_ff @(posedge i_clock or negedge rstn) begin
      if (!rstn) begin
         filt_q <= 1'b1;
         cnt_q <= 2'h0;
      end else if (db_q == CMPEV_DB_NONE) begin
         filt_q <= result;
         cnt_q <= 2'h0;
      end else if (result == filt_q || !cmp_stable) begin
         cnt_q <= 2'h0;
      end else if (cnt_q == need) begin
         filt_q <= result;
         cnt_q <= 2'h0;
      end else begin
         cnt_q <= cnt_q + 2'h1;
      end
   end

   // edge detection on the filtered result
   always_ff @(posedge i_clock or negedge rstn) begin
      if (!rstn) begin
         filt_prev_q <= 1'b1;
      end else begin
         filt_prev_q <= filt_q;
      end
   end
   assign rise = filt_q && !filt_prev_q;
   assign fall = !filt_q && filt_prev_q;
   assign event_hit = dir_q ? fall : rise;
   assign wake_hit = (rise || fall) && i_green_mode && !i_powerdown_mode;

   // sticky status; set wins over write-one clear
   assign wr_irq = i_bus.wr && i_bus.addr == CMPEV_ADDR_IRQ;
   always_ff @(posedge i_clock or negedge rstn) begin
      if (!rstn) begin
         irq_q <= CMPEV_RST_IRQ;
      end else begin
         irq_q <= (irq_q & ~(wr_irq ? i_bus.wdata[1:0] : 2'h0))
            | {wake_hit, event_hit};
      end
   end

   assign o_irq = |(irq_q & mask_q);
   assign o_wakeup = wake_hit;

   // reference generator
   assign o_ref_enable = en_q;
   assign o_ref_level_select = ref_q;

   // channel takeover, one per candidate pin
   genvar g;
   generate
      for (g = 0; g < CMPEV_NCHAN; g = g + 1) begin : g_chan
         assign o_pins.take[g] = en_q && (chan_q == 4'(g));
         assign o_pins.neg_sel[g] = en_q && (chan_q == 4'(g));
      end
   endgenerate

   // result output pin
   assign o_result_out_pin = pinen_q ? result : i_gpio_p00_out;
   assign o_result_out_pin_oe = pinen_q ? 1'b1 : i_gpio_p00_oe;

   // register readback
   always_comb begin
      rdata_d = 8'h00;
      case (i_bus.addr)
         CMPEV_ADDR_CONTROL: rdata_d = {en_q, result, ref_q, chan_q};
         CMPEV_ADDR_CONFIG: rdata_d = {4'h0, db_q, pinen_q, dir_q};
         CMPEV_ADDR_IRQ: rdata_d = {6'h00, irq_q};
         CMPEV_ADDR_MASK: rdata_d = {6'h00, mask_q};
         CMPEV_ADDR_WAKE: rdata_d = {7'h00, filt_q};
         default: rdata_d = 8'h00;
      endcase
   end

   always_ff @(posedge i_clock or negedge rstn) begin
      if (!rstn) begin
         rdata_q <= 8'h00;
      end else if (i_bus.rd) begin
         rdata_q <= rdata_d;
      end else begin
         rdata_q <= 8'h00;
      end
   end
   assign o_rdata = rdata_q;
endmodule

// File: test/cmpev_analog.sv
// Purpose: comparator output stand-in
// Assumes: level chosen by the bench
// Notes: chatter toggles each cycle like a slow input at threshold
`timescale 1ns/1ps
module cmpev_analog (
   input wire logic i_clock,
   input wire logic i_above,
   input wire logic i_chatter,
   output logic o_raw
);
   initial o_raw = 1'b0;
   always @(negedge i_clock) begin
      o_raw <= i_chatter ? ~o_raw : i_above;
   end
endmodule

// File: test/cmpev_top_assertions.sv
// Purpose: port checks for the comparator event block
// Assumes: one clock domain
// Notes: bound to cmpev_top below
`timescale 1ns/1ps
module cmpev_top_assertions (
   input wire logic i_clock,
   input wire logic i_rstn,
   input wire cmpev_pkg::cmpev_bus_t i_bus,
   input wire logic [7:0] o_rdata,
   input wire logic o_ref_enable,
   input wire logic [1:0] o_ref_level_select,
   input wire cmpev_pkg::cmpev_pins_t o_pins,
   input wire logic i_powerdown_mode,
   input wire logic i_green_mode,
   input wire logic o_wakeup,
   input wire logic o_irq
);
   import cmpev_pkg::*;
   default clocking @(posedge i_clock);
   endclocking
   default disable iff (!i_rstn);
   sequence rd_ctl;
      i_bus.rd && i_bus.addr == CMPEV_ADDR_CONTROL;
   endsequence
   a_off_result: assert property (
      rd_ctl ##0 !o_ref_enable |=> o_rdata[6]) else $error("result not 1");
   a_ref_read: assert property (
      rd_ctl |=> o_rdata[5:4] == $past(o_ref_level_select))
      else $error("ref field mismatch");
   a_idle_pins: assert property (!o_ref_enable |-> o_pins.take == '0)
      else $error("pin taken while off");
   a_one_pin: assert property ($onehot0(o_pins.take))
      else $error("several pins taken");
   a_take_conn: assert property (o_pins.take == o_pins.neg_sel)
      else $error("take and connect differ");
   a_no_pd_wake: assert property (i_powerdown_mode |-> !o_wakeup)
      else $error("wake in power-down");
   a_green_only: assert property (o_wakeup |-> i_green_mode)
      else $error("wake outside green");
   a_irq_sticky: assert property (o_irq && !i_bus.wr |=> o_irq)
      else $error("irq dropped");
endmodule
bind cmpev_top cmpev_top_assertions cmpev_top_assertions_i (
   .i_clock(i_clock), .i_rstn(i_rstn), .i_bus(i_bus), .o_rdata(o_rdata),
   .o_ref_enable(o_ref_enable), .o_ref_level_select(o_ref_level_select),
   .o_pins(o_pins), .i_powerdown_mode(i_powerdown_mode),
   .i_green_mode(i_green_mode), .o_wakeup(o_wakeup), .o_irq(o_irq));

// File: test/cmpev_top_bench.sv
// Purpose: register level tests of the comparator event block
// Assumes: 25 ns clock
// Notes: expectations follow the register map
`timescale 1ns/1ps
module cmpev_top_bench;
   import cmpev_pkg::*;
   logic clk = 0, rstn = 0, above = 0, chat = 0, gout = 0, goe = 0;
   logic green = 0, pd = 0, wake, irq, pin, pin_oe, ref_en, raw;
   logic [1:0] refsel;
   logic [7:0] rdata;
   cmpev_bus_t bus = '0;
   cmpev_pins_t pins;
   int errors = 0, checks_done = 0, wakes = 0;
   cmpev_top cmpev_top_i (.i_clock(clk), .i_rstn(rstn), .i_bus(bus),
      .o_rdata(rdata), .i_cmp_raw(raw), .o_ref_enable(ref_en),
      .o_ref_level_select(refsel), .o_pins(pins), .i_gpio_p00_out(gout),
      .i_gpio_p00_oe(goe), .o_result_out_pin(pin),
      .o_result_out_pin_oe(pin_oe), .i_green_mode(green),
      .i_powerdown_mode(pd), .o_wakeup(wake), .o_irq(irq));
   cmpev_analog cmpev_analog_i (.i_clock(clk), .i_above(above),
      .i_chatter(chat), .o_raw(raw));
   initial begin
      forever #12.5 clk = ~clk;
   end
   always @(posedge clk) wakes <= wakes + int'(wake);
   task automatic chk(input logic [11:0] got, exp);
      checks_done++;
      if (got !== exp) begin
         errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic wr(input logic [7:0] a, d);
      bus <= '{a, d, 1'b1, 1'b0};
      @(posedge clk);
      bus <= '0;
      @(posedge clk);
   endtask
   task automatic rd(input logic [7:0] a, exp);
      bus <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge clk);
      bus <= '0;
      #1 chk(rdata, exp);
      @(posedge clk);
   endtask
   task automatic end_sim();
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      cyc(12);
      rstn <= 1;
      cyc(3);
      rd(CMPEV_ADDR_CONTROL, 8'h40);
      rd(CMPEV_ADDR_CONFIG, 8'h00);
      rd(8'h10, 8'h00);
      for (int c = 0; c < 16; c++) begin
         wr(CMPEV_ADDR_CONTROL, {2'b10, 2'(c), 4'(c)});
         chk(pins.take, c < 12 ? 12'h001 << c : 12'h000);
         chk({ref_en, refsel}, {1'b1, 2'(c)});
      end
      wr(CMPEV_ADDR_CONTROL, 8'h03);
      chk(pins.take, 12'h000);
      $display("test decode done");
      wr(CMPEV_ADDR_MASK, 8'h01);
      wr(CMPEV_ADDR_CONFIG, 8'h0C);
      wr(CMPEV_ADDR_CONTROL, 8'h80);
      cyc(8);
      wr(CMPEV_ADDR_IRQ, 8'hFF);
      above <= 1;
      cyc(10);
      chk(irq, 1'b1);
      rd(CMPEV_ADDR_WAKE, 8'h01);
      rd(CMPEV_ADDR_CONTROL, 8'hC0);
      above <= 0;
      cyc(10);
      rd(CMPEV_ADDR_IRQ, 8'h01);
      wr(CMPEV_ADDR_IRQ, 8'h01);
      chk(irq, 1'b0);
      $display("test edge done");
      wr(CMPEV_ADDR_CONFIG, 8'h09);
      above <= 1;
      cyc(10);
      wr(CMPEV_ADDR_IRQ, 8'hFF);
      chat <= 1;
      cyc(12);
      chat <= 0;
      cyc(10);
      rd(CMPEV_ADDR_IRQ, 8'h00);
      above <= 0;
      cyc(10);
      rd(CMPEV_ADDR_IRQ, 8'h01);
      wr(CMPEV_ADDR_IRQ, 8'hFF);
      $display("test filter done");
      green <= 1;
      above <= 1;
      cyc(10);
      above <= 0;
      cyc(10);
      chk(12'(wakes), 12'h002);
      rd(CMPEV_ADDR_IRQ, 8'h03);
      pd <= 1;
      above <= 1;
      cyc(10);
      chk(12'(wakes), 12'h002);
      above <= 0;
      gout <= 1;
      cyc(10);
      chk({pin, pin_oe}, 2'b10);
      wr(CMPEV_ADDR_CONFIG, 8'h0B);
      chk({pin, pin_oe}, 2'b01);
      $display("test wake and pin done");
      end_sim();
   end
   initial begin
      #100us;
      errors++;
      end_sim();
   end
endmodule
